// ---- design/led_flash_mode_timer_ctrl.sv ----
// top: apb registers, mode decode and flash trigger control
`timescale 1ns/1ps
module led_flash_mode_timer_ctrl
	import led_flash_pkg::*;
#(
	parameter int tick_shift = 14
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic strobe_pin,
	input wire logic voltage_mode_force_input,
	input wire logic led_short_detect,
	input wire logic led_open_detect,
	input wire logic over_temp_detect,
	input wire logic gpio_in,
	output logic gpio_out,
	output logic gpio_oe,
	output power_ctrl_s power_ctrl,
	output logic current_limit,
	output logic voltage_clamp
);

	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] output_voltage_select;
		logic software_start_bit;
		logic strobe_type_select;
		logic dim_enable;
		logic [2:0] torch_current_setting;
		logic [2:0] flash_current_setting;
		logic [4:0] safety_timer_duration;
		logic [2:0] general_purpose_timer;
		logic led_failure_flag;
		logic over_temperature_flag;
		logic sw_timeout_flag;
		logic gpio_mask_mode;
		logic gpio_dir;
		logic gpio_level;
		logic [1:0] strobe_sync;
		logic [1:0] force_sync;
		logic [1:0] short_sync;
		logic [1:0] open_sync;
		logic [1:0] temp_sync;
		logic [1:0] gpin_sync;
		logic strobe_prev;
		logic start_prev;
		logic [1:0] prev_mode;
		timer_state_e tstate;
		logic [31:0] rdata;
		power_ctrl_s pc;
	} top_s;

	top_s state;
	top_s next_state;

	logic t_running;
	logic t_timeout;
	logic t_start;
	logic t_stop;
	logic [4:0] t_dur;

	function automatic logic is_write(input logic [7:0] a, input logic [7:0] target);
		is_write = psel && penable && pwrite && (a == target);
	endfunction

	function automatic logic is_read(input logic [7:0] a, input logic [7:0] target);
		is_read = psel && penable && !pwrite && (a == target);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == addr_ctrl) || (a == addr_level) || (a == addr_timer) ||
			(a == addr_status) || (a == addr_gpio);
	endfunction

	// combinational helpers from synchronised levels
	logic strobe_s;
	logic force_s;
	logic mask_active;
	logic trigger_level;
	logic trigger_edge;
	assign strobe_s = state.strobe_sync[1];
	assign force_s = state.force_sync[1];
	assign mask_active = state.gpio_mask_mode && state.gpin_sync[1];
	assign trigger_level = strobe_s || state.software_start_bit;
	assign trigger_edge = (strobe_s && !state.strobe_prev) ||
		(state.software_start_bit && !state.start_prev);

	led_safety_timer #(
		.count_w(24),
		.dur_w(5),
		.tick_shift(tick_shift)
	) u_timer (
		.clk(clk),
		.rstn(rstn),
		.start(t_start),
		.stop(t_stop),
		.duration(t_dur),
		.running(t_running),
		.timeout_signal(t_timeout)
	);

	always_comb
	begin
		t_start = 1'b0;
		t_stop = 1'b0;
		t_dur = state.safety_timer_duration;
		case (state.mode)
			mode_flash:
			begin
				if (!force_s || force_s)
				begin
					t_start = trigger_edge;
					// masking never touches the timer inputs
					t_stop = !state.strobe_type_select && !trigger_level;
				end
			end
			mode_voltage:
			begin
				t_start = state.software_start_bit && !state.start_prev;
				t_dur = {2'h0, state.general_purpose_timer};
			end
			default:
			begin
				t_stop = 1'b1;
			end
		endcase
		if (state.temp_sync[1])
		begin
			t_stop = 1'b1;
		end
	end

	always_comb
	begin
		next_state = state;
		next_state.strobe_sync = {state.strobe_sync[0], strobe_pin};
		next_state.force_sync = {state.force_sync[0], voltage_mode_force_input};
		next_state.short_sync = {state.short_sync[0], led_short_detect};
		next_state.open_sync = {state.open_sync[0], led_open_detect};
		next_state.temp_sync = {state.temp_sync[0], over_temp_detect};
		next_state.gpin_sync = {state.gpin_sync[0], gpio_in};
		next_state.strobe_prev = strobe_s;
		next_state.start_prev = state.software_start_bit;
		next_state.prev_mode = state.mode;

		// register writes take effect at the access edge only
		if (is_write(paddr, addr_ctrl))
		begin
			next_state.mode = pwdata[ctrl_mode_lsb +: 2];
			next_state.output_voltage_select = pwdata[ctrl_ov_lsb +: 2];
			next_state.software_start_bit = pwdata[ctrl_start_bit];
			next_state.strobe_type_select = pwdata[ctrl_strobe_type_bit];
			next_state.dim_enable = pwdata[ctrl_dim_bit];
		end
		if (is_write(paddr, addr_level))
		begin
			next_state.torch_current_setting = pwdata[level_torch_lsb +: 3];
			next_state.flash_current_setting = pwdata[level_flash_lsb +: 3];
		end
		if (is_write(paddr, addr_timer))
		begin
			next_state.safety_timer_duration = pwdata[timer_safety_lsb +: 5];
			next_state.general_purpose_timer = pwdata[timer_gp_lsb +: 3];
		end
		if (is_write(paddr, addr_gpio))
		begin
			next_state.gpio_mask_mode = pwdata[gpio_mask_mode_bit];
			next_state.gpio_dir = pwdata[gpio_dir_bit];
			next_state.gpio_level = pwdata[gpio_out_bit];
		end
		// status flags clear on read; a same-cycle event below wins
		if (is_read(paddr, addr_status))
		begin
			next_state.led_failure_flag = 1'b0;
			next_state.over_temperature_flag = 1'b0;
			next_state.sw_timeout_flag = 1'b0;
		end

		if (t_timeout)
		begin
			next_state.software_start_bit = 1'b0;
			if (state.mode == mode_voltage)
			begin
				next_state.sw_timeout_flag = 1'b1;
			end
		end
		if (state.short_sync[1] || state.open_sync[1])
		begin
			next_state.led_failure_flag = 1'b1;
		end
		if (state.temp_sync[1])
		begin
			next_state.mode = mode_shutdown;
			next_state.over_temperature_flag = 1'b1;
		end

		case (state.tstate)
			st_idle:
			begin
				if (t_start)
				begin
					next_state.tstate = (state.mode == mode_voltage) ? st_gp_run : st_flash;
				end
			end
			st_flash, st_gp_run:
			begin
				if (t_timeout)
				begin
					next_state.tstate = st_done;
				end
				else if (t_stop)
				begin
					next_state.tstate = st_idle;
				end
			end
			st_done:
			begin
				next_state.tstate = st_idle;
			end
			default:
			begin
				next_state.tstate = st_idle;
			end
		endcase

		// power stage decode
		next_state.pc = '0;
		next_state.pc.output_voltage_select = state.output_voltage_select;
		if (state.mode != mode_shutdown && state.prev_mode == mode_shutdown)
		begin
			next_state.pc.ref_ramp = '0;
		end
		else if (state.pc.ref_ramp != '1)
		begin
			next_state.pc.ref_ramp = state.pc.ref_ramp + 1'b1;
		end
		else
		begin
			next_state.pc.ref_ramp = state.pc.ref_ramp;
		end
		if (state.temp_sync[1])
		begin
			next_state.pc.ref_ramp = '0;
		end
		else if (state.mode == mode_shutdown && !force_s)
		begin
			next_state.pc.ref_ramp = '0;
			next_state.pc.rectifier_on = (state.output_voltage_select == ov_bypass);
		end
		else if (state.mode == mode_voltage || (state.mode == mode_shutdown && force_s))
		begin
			next_state.pc.switch_on = 1'b1;
			next_state.pc.rectifier_on = 1'b1;
			next_state.pc.voltage_reg = 1'b1;
		end
		else
		begin
			next_state.pc.switch_on = 1'b1;
			next_state.pc.rectifier_on = 1'b1;
			next_state.pc.led_connect = 1'b1;
			next_state.pc.current_reg_on = 1'b1;
			next_state.pc.voltage_reg = force_s;
			if (state.mode == mode_flash && t_running && !state.strobe_type_select && !mask_active)
			begin
				next_state.pc.drive_flash = 1'b1;
			end
			else if (state.mode == mode_flash && t_running && state.strobe_type_select && !mask_active)
			begin
				next_state.pc.drive_flash = 1'b1;
			end
			else
			begin
				next_state.pc.drive_torch = 1'b1;
				next_state.pc.dimming_on = state.dim_enable && (state.mode == mode_torch);
			end
			next_state.pc.led_current_code = next_state.pc.drive_flash ?
				state.flash_current_setting : state.torch_current_setting;
		end

		next_state.rdata = 32'h0;
		if (psel && !penable && !pwrite)
		begin
			case (paddr)
				addr_ctrl:
				begin
					next_state.rdata[ctrl_mode_lsb +: 2] = state.mode;
					next_state.rdata[ctrl_ov_lsb +: 2] = state.output_voltage_select;
					next_state.rdata[ctrl_start_bit] = state.software_start_bit;
					next_state.rdata[ctrl_strobe_type_bit] = state.strobe_type_select;
					next_state.rdata[ctrl_dim_bit] = state.dim_enable;
				end
				addr_level:
				begin
					next_state.rdata[level_torch_lsb +: 3] = state.torch_current_setting;
					next_state.rdata[level_flash_lsb +: 3] = state.flash_current_setting;
				end
				addr_timer:
				begin
					next_state.rdata[timer_safety_lsb +: 5] = state.safety_timer_duration;
					next_state.rdata[timer_gp_lsb +: 3] = state.general_purpose_timer;
				end
				addr_status:
				begin
					next_state.rdata[stat_fail_bit] = state.led_failure_flag;
					next_state.rdata[stat_over_temperature_flag_bit] = state.over_temperature_flag;
					next_state.rdata[stat_timeout_bit] = state.sw_timeout_flag;
					next_state.rdata[stat_running_bit] = t_running;
					next_state.rdata[stat_vreg_bit] = state.pc.voltage_reg;
				end
				addr_gpio:
				begin
					next_state.rdata[gpio_mask_mode_bit] = state.gpio_mask_mode;
					next_state.rdata[gpio_dir_bit] = state.gpio_dir;
					next_state.rdata[gpio_out_bit] = state.gpio_level;
					next_state.rdata[gpio_in_bit] = state.gpin_sync[1];
				end
				default:
				begin
					next_state.rdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= '0;
			state.tstate <= st_idle;
			state.mode <= mode_shutdown;
		end
		else
		begin
			state <= next_state;
		end
	end

	// read data of every register prepared in setup, so access ends in one cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign prdata = state.rdata;
	assign power_ctrl = state.pc;
	assign gpio_out = state.gpio_level;
	assign gpio_oe = state.gpio_dir && !state.gpio_mask_mode;
	assign current_limit = state.short_sync[1];
	assign voltage_clamp = state.open_sync[1];

endmodule

// ---- design/led_flash_pkg.sv ----
// shared constants, types and register map for the led flash mode and timer control
// Behaviour
// - mode 00: shutdown, no switching, led high-z
// - shutdown, voltage field not 11: switch, rectifier off
// - shutdown, voltage field 11: rectifier stays on
// - mode 01: torch current, triggers ignored, timer off
// - mode 11: voltage regulation, led off, timer only from start bit
// - voltage mode: start bit edge runs timeout timer
// - mode 10: strobe pin or start bit trigger
// - level type: idle torch, active flash with timer
// - level type: rising edge starts safety timer
// - level type: low level or timeout stops timer
// - timeout clears the software start bit
// - flash length limited by programmed duration
// - edge type: idle torch without timeout
// - edge type: edge starts, only timeout ends; code also stops the timer on over temperature
// - shorted led: limit current, set failure flag
// - open led: clamp voltage, set failure flag
// - over_temperature_flag: stop stage, clear mode, read-clear flag
// - gp pin: plain io or flash mask
// - masking does not change timer duration
// - force input: voltage regulation, mode 00 led off
// - force low, mode 10: flash in current mode
// - enable: switch at once, ramp reference
// - dimming only in torch-only mode
// - force high, mode 01: voltage mode plus torch
package led_flash_pkg;

	localparam logic [1:0] mode_shutdown = 2'h0;
	localparam logic [1:0] mode_torch = 2'h1;
	localparam logic [1:0] mode_flash = 2'h2;
	localparam logic [1:0] mode_voltage = 2'h3;
	localparam logic [1:0] ov_bypass = 2'h3;

	// byte addresses of the apb registers
	localparam logic [7:0] addr_ctrl = 8'h00;
	localparam logic [7:0] addr_level = 8'h04;
	localparam logic [7:0] addr_timer = 8'h08;
	localparam logic [7:0] addr_status = 8'h0c;
	localparam logic [7:0] addr_gpio = 8'h10;

	// ctrl field positions
	localparam int ctrl_mode_lsb = 0;
	localparam int ctrl_ov_lsb = 2;
	localparam int ctrl_start_bit = 4;
	localparam int ctrl_strobe_type_bit = 5;
	localparam int ctrl_dim_bit = 6;
	// level field positions
	localparam int level_torch_lsb = 0;
	localparam int level_flash_lsb = 4;
	// timer field positions
	localparam int timer_safety_lsb = 0;
	localparam int timer_gp_lsb = 8;
	// status bit positions
	localparam int stat_fail_bit = 0;
	localparam int stat_over_temperature_flag_bit = 1;
	localparam int stat_timeout_bit = 2;
	localparam int stat_running_bit = 3;
	localparam int stat_vreg_bit = 4;
	// gpio field positions
	localparam int gpio_mask_mode_bit = 0;
	localparam int gpio_dir_bit = 1;
	localparam int gpio_out_bit = 2;
	localparam int gpio_in_bit = 3;

	localparam logic [4:0] ctrl_reset = 5'h00;
	localparam logic [2:0] torch_reset = 3'h0;
	localparam logic [2:0] flash_reset = 3'h0;
	localparam logic [4:0] safety_reset = 5'h00;
	localparam logic [2:0] gp_reset = 3'h0;

	localparam int ramp_w = 6;

	typedef enum logic [3:0] {
		st_idle = 4'h1,
		st_flash = 4'h2,
		st_gp_run = 4'h4,
		st_done = 4'h8
	} timer_state_e;

	typedef struct packed {
		logic switch_on;
		logic rectifier_on;
		logic led_connect;
		logic current_reg_on;
		logic voltage_reg;
		logic drive_flash;
		logic drive_torch;
		logic dimming_on;
		logic [1:0] output_voltage_select;
		logic [2:0] led_current_code;
		logic [ramp_w-1:0] ref_ramp;
	} power_ctrl_s;

endpackage

// ---- design/led_safety_timer.sv ----
// safety / general purpose timer with one-cycle timeout pulse
`timescale 1ns/1ps
module led_safety_timer
	import led_flash_pkg::*;
#(
	parameter int count_w = 24,
	parameter int dur_w = 5,
	parameter int tick_shift = 14
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic stop,
	input wire logic [dur_w-1:0] duration,
	output logic running,
	output logic timeout_signal
);

	typedef struct packed {
		logic running;
		logic timeout;
		logic [count_w-1:0] count;
		logic [count_w-1:0] limit;
	} tmr_s;

	tmr_s state;
	tmr_s next_state;

	always_comb
	begin
		next_state = state;
		next_state.timeout = 1'b0;
		if (stop)
		begin
			next_state.running = 1'b0;
		end
		else if (start && !state.running)
		begin
			next_state.running = 1'b1;
			next_state.count = '0;
			// limit latched at start so a later write cannot stretch a flash
			next_state.limit = count_w'(({{(count_w-dur_w){1'b0}}, duration} + 1'b1) << tick_shift);
		end
		else if (state.running)
		begin
			if (state.count + 1'b1 >= state.limit)
			begin
				next_state.running = 1'b0;
				next_state.timeout = 1'b1;
			end
			else
			begin
				next_state.count = state.count + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign running = state.running;
	assign timeout_signal = state.timeout;

endmodule

// ---- test/led_flash_props.sv ----
// concurrent checks on the flash mode and timer control ports
`timescale 1ns/1ps
module led_flash_props
	import led_flash_pkg::*;
#(
	parameter int tick_shift = 14
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic led_short_detect,
	input wire logic led_open_detect,
	input wire logic over_temp_detect,
	input wire power_ctrl_s power_ctrl,
	input wire logic current_limit,
	input wire logic voltage_clamp
);
	logic [4:0] dur;
	logic [15:0] run;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// mirrored duration; slack of two covers sync and output register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dur <= 5'h00;
			run <= 16'h0000;
		end
		else
		begin
			if (psel && penable && pwrite && paddr == addr_timer)
				dur <= pwdata[4:0];
			run <= power_ctrl.drive_flash ? run + 16'h0001 : 16'h0000;
		end
	end
	shutdown_led_off_a: assert property (!power_ctrl.switch_on |-> !power_ctrl.led_connect)
		else $error("led connected while not switching");
	rect_off_a: assert property (!power_ctrl.switch_on && power_ctrl.output_voltage_select != ov_bypass
		|-> !power_ctrl.rectifier_on)
		else $error("rectifier on in plain shutdown");
	rect_bypass_a: assert property (!power_ctrl.switch_on && power_ctrl.output_voltage_select == ov_bypass
		|-> power_ctrl.rectifier_on)
		else $error("rectifier off in bypass shutdown");
	vreg_led_off_a: assert property (power_ctrl.voltage_reg && !power_ctrl.led_connect
		|-> !power_ctrl.current_reg_on && !power_ctrl.drive_flash)
		else $error("current regulator on with led off");
	flash_path_a: assert property (power_ctrl.drive_flash
		|-> power_ctrl.led_connect && power_ctrl.current_reg_on && !power_ctrl.drive_torch)
		else $error("flash drive without current path");
	flash_len_a: assert property (run <= ((({11'h000, dur} + 16'h0001) << tick_shift) + 16'h0002))
		else $error("flash longer than safety duration");
	short_limit_a: assert property (led_short_detect [*4] |-> current_limit)
		else $error("short led not limited");
	open_clamp_a: assert property (led_open_detect [*4] |-> voltage_clamp)
		else $error("open led not clamped");
	hot_stop_a: assert property (over_temp_detect [*6] |-> !power_ctrl.switch_on && !power_ctrl.current_reg_on)
		else $error("power stage on while overheated");
	soft_start_a: assert property ($rose(power_ctrl.switch_on) |-> power_ctrl.ref_ramp <= 6'h01)
		else $error("reference not ramped from low");
	cover property (power_ctrl.drive_flash ##1 !power_ctrl.drive_flash);
	cover property (power_ctrl.voltage_reg && !power_ctrl.led_connect);
	cover property (over_temp_detect [*6]);
endmodule

bind led_flash_mode_timer_ctrl led_flash_props #(.tick_shift(tick_shift)) props_i (.clk(clk), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.led_short_detect(led_short_detect), .led_open_detect(led_open_detect),
	.over_temp_detect(over_temp_detect), .power_ctrl(power_ctrl), .current_limit(current_limit),
	.voltage_clamp(voltage_clamp));

// ---- test/strobe_source.sv ----
// camera strobe source: holds the strobe pin high for a commanded width
`timescale 1ns/1ps
module strobe_source
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic fire,
	input wire logic [7:0] width,
	output logic strobe_pin
);
	logic [7:0] left;
	// a fire during a pulse restarts it, so retriggers can be made
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			left <= 8'h00;
		else if (fire)
			left <= width;
		else if (left != 8'h00)
			left <= left - 8'h01;
	end
	assign strobe_pin = left != 8'h00;
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the flash mode and timer control
`timescale 1ns/1ps
module testbench;
	import led_flash_pkg::*;
	localparam int ts = 2;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, strobe, vmf, sdet, odet, otemp, gin, fire;
	logic clim, vclamp, last_err, gout, goe;
	logic [7:0] paddr, width;
	logic [31:0] pwdata, prdata, rdat;
	power_ctrl_s pc;
	int seed, checked, miscompares;
	led_flash_mode_timer_ctrl #(.tick_shift(ts)) uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strobe_pin(strobe), .voltage_mode_force_input(vmf), .led_short_detect(sdet), .led_open_detect(odet),
		.over_temp_detect(otemp), .gpio_in(gin), .gpio_out(gout), .gpio_oe(goe), .power_ctrl(pc),
		.current_limit(clim), .voltage_clamp(vclamp));
	strobe_source cam (.clk(clk), .rstn(rstn), .fire(fire), .width(width), .strobe_pin(strobe));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic int exp_len(input int d);
		return (d + 1) << ts;
	endfunction
	function automatic logic [31:0] ctrl_w(input logic [1:0] m, input logic s, input logic t, input logic dm);
		return {25'h0, dm, t, s, 2'h0, m};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		last_err = pslverr;
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	task automatic pulse(input logic [7:0] w);
		fire <= 1'b1;
		width <= w;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		cyc(20000);
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		logic [31:0] v;
		int d, g, len;
		seed = 32'h978a;
		{rstn, psel, penable, pwrite, vmf, sdet, odet, otemp, gin, fire} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		width = 8'h00;
		cyc(6);
		rstn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++)
			rdchk(8'(4 * i), 32'h0);
		chk(last_err, 1'b1);
		repeat (4)
		begin
			v = $random(seed) & 32'h77;
			xfer(1'b1, addr_level, v);
			rdchk(addr_level, v);
		end
		for (int ov = 0; ov < 4; ov++)
		begin
			xfer(1'b1, addr_ctrl, 32'(ov << ctrl_ov_lsb));
			cyc(4);
			chk(pc.switch_on, 1'b0);
			chk(pc.rectifier_on, ov == 3);
		end
		vmf <= 1'b1;
		cyc(6);
		chk({pc.voltage_reg, pc.led_connect, pc.output_voltage_select}, {2'h2, ov_bypass});
		vmf <= 1'b0;
		xfer(1'b1, addr_ctrl, ctrl_w(mode_torch, 0, 0, 1));
		pulse(20);
		cyc(8);
		chk({pc.drive_torch, pc.drive_flash, pc.dimming_on}, 3'h5);
		chk(pc.led_current_code, v[2:0]);
		vmf <= 1'b1;
		cyc(6);
		chk({pc.voltage_reg, pc.led_connect, pc.drive_torch}, 3'h7);
		vmf <= 1'b0;
		cyc(4);
		rdchk(addr_status, 32'h0);
		d = 4 + ($unsigned($random(seed)) % 4);
		len = exp_len(d);
		xfer(1'b1, addr_timer, d);
		xfer(1'b1, addr_ctrl, ctrl_w(mode_flash, 0, 0, 1));
		cyc(3);
		chk({pc.drive_torch, pc.dimming_on}, 2'h2);
		pulse(8);
		cyc(6);
		chk(pc.drive_flash, 1'b1);
		cyc(10);
		chk({pc.drive_flash, pc.drive_torch}, 2'h1);
		pulse(60);
		cyc(6);
		chk({pc.drive_flash, pc.voltage_reg}, 2'h2);
		chk(pc.led_current_code, v[6:4]);
		cyc(len - 6);
		chk(pc.drive_flash, 1'b1);
		cyc(8);
		chk(pc.drive_flash, 1'b0);
		cyc(60);
		xfer(1'b1, addr_ctrl, ctrl_w(mode_flash, 1, 0, 1));
		cyc(8);
		chk(pc.drive_flash, 1'b1);
		cyc(len + 4);
		rdchk(addr_ctrl, ctrl_w(mode_flash, 0, 0, 1));
		xfer(1'b1, addr_ctrl, ctrl_w(mode_flash, 0, 1, 0));
		cyc(3);
		chk(pc.drive_torch, 1'b1);
		pulse(2);
		cyc(10);
		chk(pc.drive_flash, 1'b1);
		pulse(2);
		cyc(len - 10);
		chk(pc.drive_flash, 1'b1);
		cyc(8);
		chk(pc.drive_flash, 1'b0);
		gin <= 1'b1;
		xfer(1'b1, addr_gpio, 32'h1);
		chk(goe, 1'b0);
		pulse(2);
		cyc(8);
		chk({pc.drive_torch, pc.drive_flash}, 2'h2);
		rdchk(addr_status, 32'h1 << stat_running_bit);
		gin <= 1'b0;
		cyc(4);
		chk(pc.drive_flash, 1'b1);
		cyc(len);
		xfer(1'b1, addr_gpio, 32'h6);
		chk({gout, goe}, 2'h3);
		g = 1 + ($unsigned($random(seed)) % 3);
		xfer(1'b1, addr_timer, (g << timer_gp_lsb) | d);
		xfer(1'b1, addr_ctrl, ctrl_w(mode_voltage, 1, 0, 0));
		cyc(4);
		chk({pc.voltage_reg, pc.led_connect, pc.current_reg_on}, 3'h4);
		cyc(exp_len(g) + 10);
		rdchk(addr_status, 32'h14);
		rdchk(addr_status, 32'h10);
		rdchk(addr_ctrl, ctrl_w(mode_voltage, 0, 0, 0));
		{sdet, odet, otemp} <= 3'h7;
		cyc(8);
		chk({clim, vclamp, pc.switch_on}, 3'h6);
		{sdet, odet, otemp} <= 3'h0;
		cyc(4);
		rdchk(addr_ctrl, 32'h0);
		rdchk(addr_status, 32'h3);
		rdchk(addr_status, 32'h0);
		tally_and_finish();
	end
endmodule
